// File: pfr_pkg.sv
// Purpose: shared constants and carriers for fault routing and counting
// Assumes: four pwm engines, one clock domain
// Notes: event vector layout is fixed by the index constants below
package pfr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int N_ENG = 4;
    localparam int N_FMOD = 4;
    localparam int N_DCMP = 4;
    localparam int N_ACMP = 7;
    localparam int N_FPIN = 4;
    localparam int N_ENG_EVT = 5;
    localparam int N_CLKF = 2;
    localparam int ERR_W = 10;
    localparam int ACMP_REF_W = 7;

    ////////////////////////////////////////////////////////////////////////
    // Fault module slots inside one engine
    localparam int FM_CYC = 0;
    localparam int FM_BOTH = 1;
    localparam int FM_A = 2;
    localparam int FM_B = 3;

    ////////////////////////////////////////////////////////////////////////
    // Event vector positions
    localparam int EV_DCMP = 0;
    localparam int EV_ACMP = EV_DCMP + N_DCMP;
    localparam int EV_FPIN = EV_ACMP + N_ACMP;
    localparam int EV_ENG = EV_FPIN + N_FPIN;
    localparam int EV_CLKF = EV_ENG + N_ENG * N_ENG_EVT;
    localparam int EV_DCM = EV_CLKF + N_CLKF;
    localparam int N_EV = EV_DCM + 1;

    ////////////////////////////////////////////////////////////////////////
    // Asynchronous input positions in the synchroniser
    localparam int AS_ACMP = 0;
    localparam int AS_FPIN = AS_ACMP + N_ACMP;
    localparam int AS_CLKF = AS_FPIN + N_FPIN;
    localparam int AS_PCM = AS_CLKF + N_CLKF;
    localparam int N_ASYNC = AS_PCM + N_ENG;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_SYNC = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic cur_limit;
        logic over_volt;
        logic ext_a;
        logic ext_b;
        logic ideal_diode_emulation;
    } pfr_eng_evt_t;

    typedef struct packed {
        logic en;
        logic inv;
    } pfr_pin_cfg_t;

    typedef struct packed {
        logic en;
        logic above;
        logic [ERR_W-1:0] thresh;
    } pfr_dcmp_cfg_t;

endpackage : pfr_pkg

// File: pfr_fault_mod.sv
// Purpose: one counting fault module, shared by all four engine slots
// Assumes: cycle start is a one-cycle pulse from the pwm engine
// Notes: flag clears only while the channel enable is low
`timescale 1ns/1ns
`default_nettype none
module pfr_fault_mod #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Engine control
    input wire logic i_fault_en,
    input wire logic i_chan_en,
    input wire logic i_cycle_start,
    // Fault input and limit
    input wire logic i_fault,
    input wire logic [CNT_W-1:0] i_max_count,
    // Result
    output logic o_hit,
    output logic o_flag
);
    import pfr_pkg::*;

    logic seen_q, seen_d;
    logic flag_q, flag_d;
    logic [CNT_W:0] cnt_q, cnt_d;
    logic [CNT_W:0] base;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        seen_d = seen_q;
        flag_d = flag_q;
        cnt_d = cnt_q;
        base = (i_cycle_start && !seen_q) ? '0 : cnt_q;
        hit = i_fault_en && i_fault && (i_cycle_start || !seen_q);
        if (!i_chan_en) begin
            seen_d = 1'b0;
            flag_d = RST_FLAG;
            cnt_d = '0;
        end else begin
            if (i_cycle_start) begin
                seen_d = 1'b0;
                cnt_d = base;
            end
            if (hit) begin
                seen_d = 1'b1;
                // Saturate so a long run never wraps back under the limit
                cnt_d = (&base) ? base : base + 1'b1;
            end
            if (hit && (cnt_d > {1'b0, i_max_count})) begin
                flag_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            seen_q <= 1'b0;
            flag_q <= RST_FLAG;
            cnt_q <= '0;
        end else if (i_ce) begin
            seen_q <= seen_d;
            flag_q <= flag_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_hit = hit;
    assign o_flag = flag_q;

endmodule : pfr_fault_mod
`default_nettype wire

// File: pfr_fault_route.sv
// Purpose: route fault sources to the fault modules of four pwm engines
// Assumes: comparator, pin and clock-monitor levels are asynchronous
// Notes: routed events are registered once before the fault modules
//
// Function
// - Four fault modules in every engine
// - Identical modules, only attachment differs
// - Detect at once, count once per cycle
// - Flag when consecutive count exceeds limit
// - Flag holds until channel enable low
// - One channel enable clears all four
// - One fault enable for all four
// - Many sources may feed one input
// - One source may feed every engine
// - Each input selects any event combination
// - One cycle-by-cycle block per engine
// - Four threshold comparators on converter results
// - Seven analog comparators with thresholds, faults
// - Fault pins with enable and polarity
// - Five selectable fault events per engine
// - Fast and slow oscillator failure sources
// - Discontinuous conduction detection is routable
`timescale 1ns/1ns
`default_nettype none
module pfr_fault_route #(
    parameter int CNT_W = 4
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Engine control
    input wire logic [pfr_pkg::N_ENG-1:0] i_fault_en,
    input wire logic [pfr_pkg::N_ENG-1:0] i_chan_en,
    input wire logic [pfr_pkg::N_ENG-1:0] i_cycle_start,
    // Error converter comparators
    input wire logic [pfr_pkg::N_DCMP-1:0][pfr_pkg::ERR_W-1:0] i_err,
    input wire logic [pfr_pkg::N_DCMP-1:0] i_err_valid,
    input wire pfr_pkg::pfr_dcmp_cfg_t [pfr_pkg::N_DCMP-1:0] i_dcmp_cfg,
    // Analog comparators
    input wire logic [pfr_pkg::N_ACMP-1:0] i_acmp_raw,
    input wire pfr_pkg::pfr_pin_cfg_t [pfr_pkg::N_ACMP-1:0] i_acmp_cfg,
    input wire logic [pfr_pkg::N_ACMP-1:0][pfr_pkg::ACMP_REF_W-1:0]
        i_acmp_thresh,
    // External fault pins
    input wire logic [pfr_pkg::N_FPIN-1:0] i_fpin_raw,
    input wire pfr_pkg::pfr_pin_cfg_t [pfr_pkg::N_FPIN-1:0] i_fpin_cfg,
    // Engine events
    input wire pfr_pkg::pfr_eng_evt_t [pfr_pkg::N_ENG-1:0] i_eng_evt,
    input wire pfr_pkg::pfr_eng_evt_t [pfr_pkg::N_ENG-1:0] i_eng_evt_en,
    // Oscillator failure and conduction mode
    input wire logic [pfr_pkg::N_CLKF-1:0] i_clk_fail_raw,
    input wire logic [pfr_pkg::N_CLKF-1:0] i_clk_fail_en,
    input wire logic i_dcm_det,
    input wire logic i_dcm_en,
    // Peak current cycle-by-cycle
    input wire logic [pfr_pkg::N_ENG-1:0] i_pcm_trip_raw,
    input wire logic [pfr_pkg::N_ENG-1:0] i_cbc_en,
    input wire logic [pfr_pkg::N_ENG-1:0] i_cbc_match_b,
    // Routing and limits
    input wire logic [pfr_pkg::N_ENG-1:0][pfr_pkg::N_FMOD-1:0]
        [pfr_pkg::N_EV-1:0] i_fault_sel,
    input wire logic [pfr_pkg::N_ENG-1:0][pfr_pkg::N_FMOD-1:0]
        [CNT_W-1:0] i_max_count,
    // Results
    output logic [pfr_pkg::N_ENG-1:0][pfr_pkg::N_FMOD-1:0] o_fault_flag,
    output logic [pfr_pkg::N_ENG-1:0] o_kill_a,
    output logic [pfr_pkg::N_ENG-1:0] o_kill_b,
    output logic [pfr_pkg::N_ENG-1:0] o_cbc_trunc,
    output logic [pfr_pkg::N_EV-1:0] o_event,
    output logic [pfr_pkg::N_ACMP-1:0][pfr_pkg::ACMP_REF_W-1:0] o_acmp_ref
);
    import pfr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (CNT_W < 1 || CNT_W > 16) begin : g_chk_cnt
        $error("CNT_W must lie between 1 and 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchroniser for asynchronous levels
    logic [N_ASYNC-1:0] raw;
    logic [N_ASYNC-1:0] s1_q, s2_q, s3_q;
    logic [N_ASYNC-1:0] flt_q, flt_d;
    logic [N_ASYNC-1:0] agree;

    assign raw = {i_pcm_trip_raw, i_clk_fail_raw, i_fpin_raw, i_acmp_raw};

    // A change is taken only once the two late stages agree
    always_comb begin
        agree = ~(s2_q ^ s3_q);
        flt_d = (agree & s2_q) | (~agree & flt_q);
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_q <= {N_ASYNC{RST_SYNC}};
            s2_q <= {N_ASYNC{RST_SYNC}};
            s3_q <= {N_ASYNC{RST_SYNC}};
            flt_q <= {N_ASYNC{RST_SYNC}};
        end else if (i_ce) begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event sources
    logic [N_DCMP-1:0] dcmp_q, dcmp_d;
    logic [N_EV-1:0] ev_q, ev_d;
    logic [N_ACMP-1:0][ACMP_REF_W-1:0] aref_q, aref_d;
    logic [N_ACMP-1:0] acmp_s;
    logic [N_FPIN-1:0] fpin_s;
    logic [N_CLKF-1:0] clkf_s;
    logic [N_ENG-1:0] pcm_s;

    assign acmp_s = flt_q[AS_ACMP +: N_ACMP];
    assign fpin_s = flt_q[AS_FPIN +: N_FPIN];
    assign clkf_s = flt_q[AS_CLKF +: N_CLKF];
    assign pcm_s = flt_q[AS_PCM +: N_ENG];

    always_comb begin
        dcmp_d = dcmp_q;
        ev_d = '0;
        // Thresholds pass to the analog references through a flop
        aref_d = i_acmp_thresh;
        for (int i = 0; i < N_DCMP; i++) begin
            if (!i_dcmp_cfg[i].en) begin
                dcmp_d[i] = 1'b0;
            end else if (i_err_valid[i]) begin
                // Result holds between samples so a trip lasts a sample
                dcmp_d[i] = i_dcmp_cfg[i].above ?
                    ($signed(i_err[i]) > $signed(i_dcmp_cfg[i].thresh)) :
                    ($signed(i_err[i]) < $signed(i_dcmp_cfg[i].thresh));
            end
        end
        ev_d[EV_DCMP +: N_DCMP] = dcmp_q;
        for (int i = 0; i < N_ACMP; i++) begin
            ev_d[EV_ACMP + i] = i_acmp_cfg[i].en &
                (acmp_s[i] ^ i_acmp_cfg[i].inv);
        end
        for (int i = 0; i < N_FPIN; i++) begin
            ev_d[EV_FPIN + i] = i_fpin_cfg[i].en &
                (fpin_s[i] ^ i_fpin_cfg[i].inv);
        end
        for (int e = 0; e < N_ENG; e++) begin
            ev_d[EV_ENG + e * N_ENG_EVT +: N_ENG_EVT] =
                i_eng_evt[e] & i_eng_evt_en[e];
        end
        ev_d[EV_CLKF +: N_CLKF] = clkf_s & i_clk_fail_en;
        ev_d[EV_DCM] = i_dcm_det & i_dcm_en;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dcmp_q <= '0;
            ev_q <= '0;
            aref_q <= '0;
        end else if (i_ce) begin
            dcmp_q <= dcmp_d;
            ev_q <= ev_d;
            aref_q <= aref_d;
        end
    end

    assign o_event = ev_q;
    assign o_acmp_ref = aref_q;

    ////////////////////////////////////////////////////////////////////////
    // Fault modules
    logic [N_ENG-1:0][N_FMOD-1:0] fin;
    logic [N_ENG-1:0][N_FMOD-1:0] flag_w;
    logic [N_ENG-1:0][N_FMOD-1:0] hit_w;
    logic [N_ENG-1:0] pcm_hit;

    assign pcm_hit = pcm_s & i_cbc_en & i_chan_en;

    for (genvar e = 0; e < N_ENG; e++) begin : g_eng
        for (genvar m = 0; m < N_FMOD; m++) begin : g_fm
            logic sel_any;
            assign sel_any = |(ev_q & i_fault_sel[e][m]);
            if (m == FM_CYC) begin : g_cyc
                assign fin[e][m] = sel_any | pcm_hit[e];
            end else begin : g_oth
                assign fin[e][m] = sel_any;
            end
            pfr_fault_mod #(
                .CNT_W(CNT_W)
            ) u_fm (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn),
                .i_ce(i_ce),
                .i_fault_en(i_fault_en[e]),
                .i_chan_en(i_chan_en[e]),
                .i_cycle_start(i_cycle_start[e]),
                .i_fault(fin[e][m]),
                .i_max_count(i_max_count[e][m]),
                .o_hit(hit_w[e][m]),
                .o_flag(flag_w[e][m])
            );
        end
    end

    assign o_fault_flag = flag_w;

    ////////////////////////////////////////////////////////////////////////
    // Cycle-by-cycle block and output attachment
    logic [N_ENG-1:0] trunc_q, trunc_d;
    logic [N_ENG-1:0] kill_a_q, kill_a_d;
    logic [N_ENG-1:0] kill_b_q, kill_b_d;

    always_comb begin
        trunc_d = trunc_q;
        kill_a_d = '0;
        kill_b_d = '0;
        for (int e = 0; e < N_ENG; e++) begin
            if (!i_chan_en[e] || i_cycle_start[e]) begin
                trunc_d[e] = 1'b0;
            end
            // A trip in the start cycle still truncates the new pulse
            if (pcm_hit[e]) begin
                trunc_d[e] = 1'b1;
            end
            kill_a_d[e] = flag_w[e][FM_CYC] | flag_w[e][FM_BOTH] |
                flag_w[e][FM_A] | trunc_d[e];
            // B may copy the truncated A pulse to keep a half bridge even
            kill_b_d[e] = flag_w[e][FM_CYC] | flag_w[e][FM_BOTH] |
                flag_w[e][FM_B] | (trunc_d[e] & i_cbc_match_b[e]);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            trunc_q <= '0;
            kill_a_q <= '0;
            kill_b_q <= '0;
        end else if (i_ce) begin
            trunc_q <= trunc_d;
            kill_a_q <= kill_a_d;
            kill_b_q <= kill_b_d;
        end
    end

    assign o_cbc_trunc = trunc_q;
    assign o_kill_a = kill_a_q;
    assign o_kill_b = kill_b_q;

endmodule : pfr_fault_route
`default_nettype wire

// File: pfr_fault_route_chk.sv
// Purpose: port-level checks on fault routing and counting
// Assumes: engine 0 and 1 carry the watched traffic
// Notes: bound to the route module from the bench top
`timescale 1ns/1ns
`default_nettype none
module pfr_fault_route_chk (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // Watched inputs
    input wire logic [pfr_pkg::N_ENG-1:0] i_fault_en,
    input wire logic [pfr_pkg::N_ENG-1:0] i_chan_en,
    input wire pfr_pkg::pfr_eng_evt_t [pfr_pkg::N_ENG-1:0] i_eng_evt,
    input wire pfr_pkg::pfr_eng_evt_t [pfr_pkg::N_ENG-1:0] i_eng_evt_en,
    input wire logic i_dcm_det,
    input wire logic i_dcm_en,
    input wire logic [pfr_pkg::N_ACMP-1:0][pfr_pkg::ACMP_REF_W-1:0]
        i_acmp_thresh,
    // Watched outputs
    input wire logic [pfr_pkg::N_ENG-1:0][pfr_pkg::N_FMOD-1:0] o_fault_flag,
    input wire logic [pfr_pkg::N_ENG-1:0] o_kill_a,
    input wire logic [pfr_pkg::N_ENG-1:0] o_kill_b,
    input wire logic [pfr_pkg::N_ENG-1:0] o_cbc_trunc,
    input wire logic [pfr_pkg::N_EV-1:0] o_event,
    input wire logic [pfr_pkg::N_ACMP-1:0][pfr_pkg::ACMP_REF_W-1:0]
        o_acmp_ref
);
    import pfr_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    chk_clear_all: assert property (
        !i_chan_en[0] && i_ce |=> o_fault_flag[0] == 4'h0)
        else $error("flags survived a low channel enable");
    chk_flag_hold: assert property (
        o_fault_flag[0][FM_A] && i_chan_en[0] |=> o_fault_flag[0][FM_A])
        else $error("flag dropped while channel enabled");
    chk_ce_freeze: assert property (
        !i_ce |=> $stable(o_fault_flag))
        else $error("flags moved while clock enable low");
    chk_flag_gate: assert property (
        $rose(o_fault_flag[0][FM_CYC]) |->
        $past(i_fault_en[0]) || $past(i_fault_en[0], 2))
        else $error("flag rose with fault enable low");
    chk_kill_a: assert property (
        o_fault_flag[0][FM_A] && i_chan_en[0] && i_ce |=> o_kill_a[0])
        else $error("output A flag did not kill A");
    chk_kill_b: assert property (
        o_fault_flag[0][FM_B] && i_chan_en[0] && i_ce |=> o_kill_b[0])
        else $error("output B flag did not kill B");
    chk_evt_route: assert property (
        i_eng_evt[0].cur_limit && i_eng_evt_en[0].cur_limit && i_ce
        |=> o_event[EV_ENG+4])
        else $error("current limit event not routed");
    chk_evt_mask: assert property (
        !i_eng_evt_en[1].over_volt && i_ce |=> !o_event[EV_ENG+8])
        else $error("disabled engine event routed");
    chk_dcm_route: assert property (
        i_dcm_det && i_dcm_en && i_ce |=> o_event[EV_DCM])
        else $error("conduction mode event not routed");
    chk_ref_copy: assert property (
        i_ce |=> o_acmp_ref == $past(i_acmp_thresh))
        else $error("comparator reference not copied");
    chk_trunc_clear: assert property (
        (!i_chan_en[0] && i_ce) [*3] |=> !o_cbc_trunc[0])
        else $error("truncation kept with channel disabled");
endmodule : pfr_fault_route_chk
`default_nettype wire

// File: pfr_pwm_model.sv
// Purpose: switching-cycle source standing in for the pwm engines
// Assumes: all engines share one period and phase
// Notes: start pulse lasts one clock, as the engines give it
`timescale 1ns/1ns
`default_nettype none
module pfr_pwm_model #(
    parameter int PERIOD = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Cycle starts
    output logic [pfr_pkg::N_ENG-1:0] o_cycle_start
);
    logic [7:0] cnt_q;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
        end
    end
    assign o_cycle_start = {pfr_pkg::N_ENG{cnt_q == 8'(PERIOD - 1)}};
endmodule : pfr_pwm_model
`default_nettype wire

// File: test_pfr_fault_route.sv
// Purpose: self-checking bench for fault routing and counting
// Assumes: engine events and dcm are same-clock, the rest asynchronous
// Notes: cycles are eight clocks long, made by the pwm model
`timescale 1ns/1ns
`default_nettype none
module test_pfr_fault_route;
    import pfr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [N_ENG-1:0] fen = '1;
    logic [N_ENG-1:0] chen = '1;
    logic [N_ENG-1:0] pcm = '0;
    logic [N_ENG-1:0] cbc_en = '0;
    logic [N_ENG-1:0] cs;
    logic [N_EV-1:0] src = '0;
    logic [N_EV-1:0] one = N_EV'(1);
    logic [N_ENG*N_ENG_EVT-1:0] evt_en = '1;
    logic [N_DCMP-1:0][ERR_W-1:0] err = '0;
    logic [N_DCMP-1:0] err_v = '0;
    pfr_dcmp_cfg_t [N_DCMP-1:0] dcfg = '0;
    pfr_pin_cfg_t [N_FPIN-1:0] pcfg = {N_FPIN{2'b10}};
    logic [N_ACMP-1:0][ACMP_REF_W-1:0] thr = '0;
    logic [N_ENG-1:0][N_FMOD-1:0][N_EV-1:0] sel = '0;
    logic [N_ENG-1:0][N_FMOD-1:0][3:0] maxc = '0;
    logic [N_ENG-1:0][N_FMOD-1:0] flag;
    logic [N_ENG-1:0] kill_a;
    logic [N_ENG-1:0] kill_b;
    logic [N_ENG-1:0] trunc;
    logic [N_EV-1:0] ev;
    logic [N_ACMP-1:0][ACMP_REF_W-1:0] aref;
    logic [5:0] pat = 6'h3B;
    int bad_count = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    pfr_pwm_model #(.PERIOD(8)) u_pwm (.i_ref_clk(clk), .i_resetn(rst_n),
        .o_cycle_start(cs));
    pfr_fault_route #(.CNT_W(4)) dut (.i_ref_clk(clk), .i_resetn(rst_n),
        .i_ce(ce), .i_fault_en(fen), .i_chan_en(chen), .i_cycle_start(cs),
        .i_err(err), .i_err_valid(err_v), .i_dcmp_cfg(dcfg),
        .i_acmp_raw(src[EV_FPIN-1:EV_ACMP]), .i_acmp_cfg({N_ACMP{2'b10}}),
        .i_acmp_thresh(thr), .i_fpin_raw(src[EV_ENG-1:EV_FPIN]),
        .i_fpin_cfg(pcfg), .i_eng_evt(src[EV_CLKF-1:EV_ENG]),
        .i_eng_evt_en(evt_en), .i_clk_fail_raw(src[EV_DCM-1:EV_CLKF]),
        .i_clk_fail_en(2'h3), .i_dcm_det(src[EV_DCM]), .i_dcm_en(1'b1),
        .i_pcm_trip_raw(pcm), .i_cbc_en(cbc_en), .i_cbc_match_b(4'hF),
        .i_fault_sel(sel), .i_max_count(maxc), .o_fault_flag(flag),
        .o_kill_a(kill_a), .o_kill_b(kill_b), .o_cbc_trunc(trunc),
        .o_event(ev), .o_acmp_ref(aref));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp
    task automatic give_verdict;
        $display("Checked %0d, mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // Three-clock pulse inside one cycle, so a repeat count would show
    task automatic cyc(input int k, input logic v);
        @(negedge clk iff cs[0]);
        @(negedge clk);
        src[k] = v;
        repeat (3) @(negedge clk);
        src[k] = 1'b0;
        repeat (3) @(negedge clk);
    endtask : cyc
    task automatic clear_eng;
        chen = '0;
        repeat (3) @(negedge clk);
        chen = '1;
        @(negedge clk);
    endtask : clear_eng
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        cmp("flags after reset", 0, flag);
        for (int m = 0; m < N_FMOD; m++) begin
            sel[0][m][EV_ENG+4] = 1'b1;
            maxc[0][m] = 4'h2;
        end
        for (int i = 0; i < 6; i++) begin
            cyc(EV_ENG + 4, pat[i]);
            cmp("engine 0 flags", (i == 5) ? 4'hF : 4'h0, flag[0]);
        end
        cmp("engine 0 kills", 2'h3, {kill_b[0], kill_a[0]});
        cyc(EV_ENG + 4, 1'b0);
        cmp("held flags", 4'hF, flag[0]);
        ce = 1'b0;
        chen[0] = 1'b0;
        repeat (2) @(negedge clk);
        cmp("frozen flags", 4'hF, flag[0]);
        ce = 1'b1;
        repeat (2) @(negedge clk);
        chen[0] = 1'b1;
        cmp("cleared flags", 4'h0, flag[0]);
        $display("test counting done");
        maxc = '0;
        fen[0] = 1'b0;
        cyc(EV_ENG + 4, 1'b1);
        cmp("disabled flags", 4'h0, flag[0]);
        fen[0] = 1'b1;
        cyc(EV_ENG + 4, 1'b1);
        cmp("enabled flags", 4'hF, flag[0]);
        clear_eng();
        $display("test enable done");
        for (int e = 0; e < N_ENG; e++) begin
            for (int m = 0; m < N_FMOD; m++) begin
                sel[e][m][EV_DCM] = 1'b1;
            end
        end
        cyc(EV_DCM, 1'b1);
        cmp("all flags from dcm", 16'hFFFF, flag);
        clear_eng();
        cyc(EV_ENG + 4, 1'b1);
        // Only engine 0 selects the current-limit event, so only it flags
        cmp("all flags from event", 16'h000F, flag);
        clear_eng();
        $display("test mapping done");
        sel = '0;
        thr = {N_ACMP{7'h55}};
        for (int k = EV_ACMP; k < N_EV; k++) begin
            src[k] = 1'b1;
            repeat (8) @(negedge clk);
            cmp("routed events", one << k, ev);
            src[k] = 1'b0;
            repeat (8) @(negedge clk);
        end
        cmp("comparator references", thr, aref);
        evt_en = '0;
        src[EV_ENG+8] = 1'b1;
        repeat (4) @(negedge clk);
        cmp("masked event", 0, ev);
        evt_en = '1;
        src[EV_ENG+8] = 1'b0;
        pcfg[0].inv = 1'b1;
        repeat (8) @(negedge clk);
        cmp("inverted pin", one << EV_FPIN, ev);
        pcfg[0].inv = 1'b0;
        dcfg = {N_DCMP{1'b1, 1'b1, 10'h064}};
        err = {N_DCMP{10'h0C8}};
        for (int p = 0; p < 2; p++) begin
            repeat (8) @(negedge clk);
            err_v = '1;
            @(negedge clk);
            err_v = '0;
            repeat (3) @(negedge clk);
            cmp("digital compares", (p == 0) ? 4'hF : 4'h0, ev[3:0]);
            dcfg = {N_DCMP{1'b1, 1'b0, 10'h064}};
        end
        $display("test sources done");
        cbc_en[0] = 1'b1;
        pcm[0] = 1'b1;
        repeat (8) @(negedge clk);
        cmp("truncation", 2'h3, {trunc[0], flag[0][FM_CYC]});
        pcm[0] = 1'b0;
        // Synchroniser lag can push the clearing start into the next cycle
        repeat (16) @(negedge clk);
        cmp("truncation after start", 0, trunc[0]);
        clear_eng();
        cmp("cycle limit cleared", 0, flag[0]);
        $display("test cycle limit done");
        give_verdict();
    end
    // Whole run is near 730 clocks, so 200 us leaves ample margin
    initial begin
        #200000;
        bad_count++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        give_verdict();
    end
endmodule : test_pfr_fault_route
bind pfr_fault_route pfr_fault_route_chk u_chk (.i_ref_clk, .i_resetn,
    .i_ce, .i_fault_en, .i_chan_en, .i_eng_evt, .i_eng_evt_en, .i_dcm_det,
    .i_dcm_en, .i_acmp_thresh, .o_fault_flag, .o_kill_a, .o_kill_b,
    .o_cbc_trunc, .o_event, .o_acmp_ref);
`default_nettype wire
